// File: src/dlc_pkg.sv
// shared constants and types for the dram lane control block
package dlc_pkg;

  localparam int CLK_PERIOD_NS = 100;
  localparam int MUX_DELAY_NS = 40;
  localparam int CAS_DELAY_NS = 80;
  localparam int CYCLE_LEN_NS = 300;
  localparam int REFRESH_PERIOD_NS = 12500;
  localparam int REFRESH_ROWS = 256;

  // least times round up
  localparam int MUX_DELAY_CYC =
    (MUX_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAS_DELAY_CYC =
    (CAS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYCLE_LEN_CYC =
    (CYCLE_LEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // longest time rounds down
  localparam int REFRESH_CYC = REFRESH_PERIOD_NS / CLK_PERIOD_NS;

  localparam logic [2:0] MUX_TAP = 3'(MUX_DELAY_CYC);
  localparam logic [2:0] CAS_TAP = 3'(CAS_DELAY_CYC);
  localparam logic [2:0] END_TAP = 3'(CYCLE_LEN_CYC - 1);
  localparam logic [6:0] REFRESH_LAST = 7'(REFRESH_CYC - 1);

  localparam logic [1:0] CPU_DIV_LAST = 2'h2;
  localparam logic [8:0] REFRESH_ROW_RESET = 9'h000;
  localparam logic [19:0] ADDR_RESET = 20'h00000;

  typedef enum logic [1:0] {
    DLC_IDLE = 2'b00,
    DLC_CPU = 2'b01,
    DLC_HOST = 2'b10,
    DLC_REFR = 2'b11
  } dlc_state_e;

  typedef struct packed {
    logic mem_read_strobe;
    logic mem_write_strobe;
    logic io_read;
    logic io_write;
    logic bhe_b;
  } dlc_cpu_ctl_s;

  typedef struct packed {
    logic lo_en;
    logic hi_en;
    logic swap_en;
  } dlc_xcvr_s;

  typedef struct packed {
    logic ras;
    logic mux_col;
    logic cas;
    logic upper_lane_col_strobe;
    logic lower_lane_col_strobe;
    logic [8:0] addr;
  } dlc_dram_s;

endpackage : dlc_pkg

// File: src/dlc_clkgen.sv
// clock enables, divided clocks and reset synchroniser
module dlc_clkgen (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  output logic cpu_clk_o,
  output logic periph_clk_o,
  output logic timer_clk_o,
  output logic cpu_rst_b_o
);
  import dlc_pkg::*;

  logic [1:0] phase_r;
  logic [2:0] div_r;
  logic [1:0] rst_sync_r;
  logic cpu_rise;

  assign cpu_rise = (phase_r == CPU_DIV_LAST);

  // divide by three, high one phase in three
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_r <= 2'h0;
    end else if (cpu_rise) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  // three successive halvings on each processor clock edge
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_r <= 3'h0;
    end else if (cpu_rise) begin
      div_r[0] <= ~div_r[0];
      if (div_r[0]) begin
        div_r[1] <= ~div_r[1];
      end
      if (div_r[0] && div_r[1]) begin
        div_r[2] <= ~div_r[2];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cpu_clk_o <= 1'b0;
    end else begin
      cpu_clk_o <= cpu_rise;
    end
  end

  assign periph_clk_o = div_r[0];
  assign timer_clk_o = div_r[2];
  assign cpu_rst_b_o = rst_sync_r[1];

endmodule : dlc_clkgen

// File: src/dlc_lane_ctrl.sv
// lane steering, dram timing and refresh for the local processor bus

//
// Overview of operation
// - odd-address byte i/o data is swapped between low and high bus halves
// - memory: word both lanes, even byte low lane, odd byte high lane
// - byte i/o: low lane transceiver at even, swap transceiver at odd
// - clock generator makes 33% processor clock, peripheral clock, reset sync
// - address latch strobe captures the address, held through the cycle
// - rising or of memory read and write strobes starts a dram cycle
// - address mux turns to column address 40 ns after row strobe; here one 100 ns clock after
// - master column strobe asserts 80 ns after row strobe; here one 100 ns clock after, with the mux
// - lane column strobes: none for i/o, by byte lanes for memory
// - host lane selects only active while the host owns the buses
// - cpu lane enables only active while the host does not own the bus
// - one refresh at least every 12.5 us, 256 rows per 4 ms
// - timer tick every 12.5 us sets the refresh request
// - refresh requests are inhibited while the host owns the bus
// - host memory request clears a pending refresh request
// - timer clock is processor clock halved three times
// - memory is shared by processor and host, one owner at a time
// - 512 kbytes as 16 one-bit rams, two byte lanes
module dlc_lane_ctrl (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic ale_i,
  input wire logic [19:0] addr_i,
  input wire dlc_pkg::dlc_cpu_ctl_s cpu_ctl_i,
  input wire logic host_owns_i,
  input wire logic host_req_i,
  input wire logic host_mem_strobe_i,
  input wire logic [17:0] host_addr_i,
  input wire logic host_hi_byte_i,
  input wire logic host_lo_byte_i,
  output logic [19:0] latched_addr_o,
  output dlc_pkg::dlc_xcvr_s xcvr_o,
  output logic cpu_upper_lane_en_o,
  output logic cpu_lower_lane_en_o,
  output logic host_upper_lane_sel_o,
  output logic host_lower_lane_sel_o,
  output dlc_pkg::dlc_dram_s dram_o,
  output logic refresh_req_o,
  output logic cpu_clk_o,
  output logic periph_clk_o,
  output logic timer_clk_o,
  output logic cpu_rst_b_o
);
  import dlc_pkg::*;

  logic [19:0] addr_r;
  logic bhe_b_r;
  logic [17:0] host_addr_r;
  logic host_hi_r;
  logic host_lo_r;
  logic cpu_hi_r;
  logic cpu_lo_r;
  dlc_state_e state_r;
  dlc_state_e state_nxt;
  logic [2:0] tap_r;
  logic strobe_d_r;
  logic host_strobe_d_r;
  logic cpu_pend_r;
  logic host_pend_r;
  logic [6:0] tick_cnt_r;
  logic refresh_req_r;
  logic [8:0] refresh_row_r;
  logic strobe_or;
  logic cpu_start;
  logic host_start;
  logic refresh_tick;
  logic cycle_end;
  logic is_word;
  logic is_even_byte;
  logic is_odd_byte;
  logic mem_cycle;
  logic io_cycle;
  logic lane_hi;
  logic lane_lo;
  logic [8:0] row_addr;
  logic [8:0] col_addr;
  logic mem_state;
  logic lane_hi_sel;
  logic lane_lo_sel;
  logic refresh_start;

  dlc_clkgen u_clkgen (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .cpu_clk_o(cpu_clk_o),
    .periph_clk_o(periph_clk_o),
    .timer_clk_o(timer_clk_o),
    .cpu_rst_b_o(cpu_rst_b_o)
  );

  // byte lane use from a0 and the high byte enable
  function automatic logic [1:0] lane_use(input logic a0, input logic bhe_b);
    lane_use = {~bhe_b, ~a0};
  endfunction : lane_use

  // memory states that carry column timing
  function automatic logic is_mem_state(input dlc_state_e st);
    is_mem_state = (st == DLC_CPU) || (st == DLC_HOST);
  endfunction : is_mem_state

  // one lane strobe from the master strobe and its lane bit
  function automatic logic lane_strobe(input logic cas, input logic lane);
    lane_strobe = cas & lane;
  endfunction : lane_strobe

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_r <= ADDR_RESET;
      bhe_b_r <= 1'b1;
    end else if (ale_i) begin
      addr_r <= addr_i;
      bhe_b_r <= cpu_ctl_i.bhe_b;
    end
  end

  assign latched_addr_o = addr_r;

  assign is_word = ~addr_r[0] & ~bhe_b_r;
  assign is_even_byte = ~addr_r[0] & bhe_b_r;
  assign is_odd_byte = addr_r[0] & ~bhe_b_r;
  assign mem_cycle = cpu_ctl_i.mem_read_strobe | cpu_ctl_i.mem_write_strobe;
  assign io_cycle = cpu_ctl_i.io_read | cpu_ctl_i.io_write;

  // transceiver enables while the processor owns the bus
  always_comb begin
    xcvr_o = '0;
    if (!host_owns_i) begin
      if (mem_cycle) begin
        xcvr_o.lo_en = is_word | is_even_byte;
        xcvr_o.hi_en = is_word | is_odd_byte;
      end else if (io_cycle) begin
        xcvr_o.lo_en = ~addr_r[0];
        xcvr_o.swap_en = addr_r[0];
      end
    end
  end

  assign {lane_hi, lane_lo} = lane_use(addr_r[0], bhe_b_r);
  assign cpu_upper_lane_en_o = ~host_owns_i & mem_cycle & lane_hi;
  assign cpu_lower_lane_en_o = ~host_owns_i & mem_cycle & lane_lo;
  assign host_upper_lane_sel_o = host_owns_i & host_hi_byte_i;
  assign host_lower_lane_sel_o = host_owns_i & host_lo_byte_i;

  // start of a processor memory cycle on the ored strobe edge
  assign strobe_or = mem_cycle;
  assign cpu_start = strobe_or & ~strobe_d_r & ~host_owns_i;
  assign host_start = host_mem_strobe_i & ~host_strobe_d_r & host_owns_i;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      strobe_d_r <= 1'b0;
      host_strobe_d_r <= 1'b0;
    end else begin
      strobe_d_r <= strobe_or;
      host_strobe_d_r <= host_mem_strobe_i;
    end
  end

  // a start that meets a busy controller waits here
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cpu_pend_r <= 1'b0;
    end else if (cpu_start) begin
      cpu_pend_r <= 1'b1;
    end else if (state_r == DLC_IDLE) begin
      cpu_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      host_pend_r <= 1'b0;
    end else if (host_start) begin
      host_pend_r <= 1'b1;
    end else if (state_r == DLC_IDLE && !cpu_pend_r) begin
      host_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      host_addr_r <= 18'h00000;
      host_hi_r <= 1'b0;
      host_lo_r <= 1'b0;
    end else if (host_start) begin
      host_addr_r <= host_addr_i;
      host_hi_r <= host_hi_byte_i;
      host_lo_r <= host_lo_byte_i;
    end
  end

  // lane use frozen at the start of a processor cycle
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cpu_hi_r <= 1'b0;
      cpu_lo_r <= 1'b0;
    end else if (cpu_start) begin
      cpu_hi_r <= lane_hi;
      cpu_lo_r <= lane_lo;
    end
  end

  assign cycle_end = (state_r != DLC_IDLE) && (tap_r == END_TAP);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DLC_IDLE: begin
        if (cpu_pend_r) begin
          state_nxt = DLC_CPU;
        end else if (host_pend_r) begin
          state_nxt = DLC_HOST;
        end else if (refresh_req_r && !strobe_or && !host_owns_i) begin
          state_nxt = DLC_REFR;
        end
      end
      DLC_CPU, DLC_HOST, DLC_REFR: begin
        if (cycle_end) begin
          state_nxt = DLC_IDLE;
        end
      end
      default: begin
        state_nxt = DLC_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= DLC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // delay chain taps counted from row strobe
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tap_r <= 3'h0;
    end else if (state_r == DLC_IDLE || cycle_end) begin
      tap_r <= 3'h0;
    end else begin
      tap_r <= tap_r + 3'h1;
    end
  end

  // timer channel tick, only while the processor runs
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_cnt_r <= 7'h00;
    end else if (!cpu_rst_b_o || tick_cnt_r == REFRESH_LAST) begin
      tick_cnt_r <= 7'h00;
    end else begin
      tick_cnt_r <= tick_cnt_r + 7'h01;
    end
  end

  assign refresh_tick = cpu_rst_b_o && (tick_cnt_r == REFRESH_LAST);

  // host request clears, tick sets over service clear
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      refresh_req_r <= 1'b0;
    end else if (host_req_i) begin
      refresh_req_r <= 1'b0;
    end else if (refresh_tick && !host_owns_i) begin
      refresh_req_r <= 1'b1;
    end else if (refresh_start) begin
      refresh_req_r <= 1'b0;
    end
  end

  // refresh begins only from idle
  assign refresh_start = (state_r == DLC_IDLE) && (state_nxt == DLC_REFR);
  assign refresh_req_o = refresh_req_r;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      refresh_row_r <= REFRESH_ROW_RESET;
    end else if (state_r == DLC_REFR && cycle_end) begin
      refresh_row_r <= refresh_row_r + 9'h001;
    end
  end

  // 18-bit word address over 9 row and 9 column lines
  always_comb begin
    row_addr = addr_r[9:1];
    col_addr = addr_r[18:10];
    case (state_r)
      DLC_HOST: begin
        row_addr = host_addr_r[8:0];
        col_addr = host_addr_r[17:9];
      end
      DLC_REFR: begin
        row_addr = refresh_row_r;
        col_addr = refresh_row_r;
      end
      default: begin
        row_addr = addr_r[9:1];
        col_addr = addr_r[18:10];
      end
    endcase
  end

  assign mem_state = is_mem_state(state_r);

  // lane bits of whichever owner runs the cycle
  always_comb begin
    lane_hi_sel = 1'b0;
    lane_lo_sel = 1'b0;
    case (state_r)
      DLC_CPU: begin
        lane_hi_sel = cpu_hi_r;
        lane_lo_sel = cpu_lo_r;
      end
      DLC_HOST: begin
        lane_hi_sel = host_hi_r;
        lane_lo_sel = host_lo_r;
      end
      default: begin
        lane_hi_sel = 1'b0;
        lane_lo_sel = 1'b0;
      end
    endcase
  end

  always_comb begin
    dram_o = '0;
    dram_o.ras = (state_r != DLC_IDLE);
    dram_o.mux_col = mem_state && (tap_r >= MUX_TAP);
    dram_o.cas = mem_state && (tap_r >= CAS_TAP);
    dram_o.addr = dram_o.mux_col ? col_addr : row_addr;
    dram_o.upper_lane_col_strobe = lane_strobe(dram_o.cas, lane_hi_sel);
    dram_o.lower_lane_col_strobe = lane_strobe(dram_o.cas, lane_lo_sel);
  end

endmodule : dlc_lane_ctrl

// File: dv/dlc_props.sv
// port assertions for the lane control block
module dlc_props
  import dlc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire dlc_pkg::dlc_cpu_ctl_s cpu_ctl_i,
  input wire logic host_owns_i,
  input wire logic host_req_i,
  input wire dlc_pkg::dlc_xcvr_s xcvr_o,
  input wire logic cpu_upper_lane_en_o,
  input wire logic cpu_lower_lane_en_o,
  input wire logic host_upper_lane_sel_o,
  input wire logic host_lower_lane_sel_o,
  input wire dlc_pkg::dlc_dram_s dram_o,
  input wire logic refresh_req_o,
  input wire logic cpu_clk_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  logic strb;
  logic lanes;
  assign strb = cpu_ctl_i.mem_read_strobe | cpu_ctl_i.mem_write_strobe;
  assign lanes = dram_o.upper_lane_col_strobe | dram_o.lower_lane_col_strobe;
  chk_host_sel_gate: assert property (
    !host_owns_i |-> !host_upper_lane_sel_o && !host_lower_lane_sel_o)
    else $error("host lane select without ownership");
  chk_cpu_en_gate: assert property (
    host_owns_i |-> !cpu_upper_lane_en_o && !cpu_lower_lane_en_o)
    else $error("cpu lane enable while host owns");
  chk_xcvr_host: assert property (host_owns_i |-> xcvr_o == '0)
    else $error("transceiver enabled while host owns");
  chk_mem_start: assert property (
    $rose(strb) && !host_owns_i |-> ##[1:8] $rose(dram_o.ras))
    else $error("memory strobe started no row strobe");
  chk_ras_len: assert property (
    $rose(dram_o.ras) |-> dram_o.ras[*3] ##1 !dram_o.ras)
    else $error("row strobe length wrong");
  chk_mux_delay: assert property (
    $rose(dram_o.mux_col) |-> $past(dram_o.ras) && !$past(dram_o.ras, 2))
    else $error("column select not one cycle after row strobe");
  chk_cas_delay: assert property (
    $rose(dram_o.cas) |-> $past(dram_o.ras) && !$past(dram_o.ras, 2)
    ##1 dram_o.cas ##1 !dram_o.cas && !dram_o.ras)
    else $error("column strobe timing wrong");
  chk_lane_cas: assert property (lanes |-> dram_o.cas)
    else $error("lane strobe without column strobe");
  chk_refr_clear: assert property (host_req_i |=> !refresh_req_o)
    else $error("host request left refresh pending");
  chk_refr_block: assert property (
    host_owns_i && !refresh_req_o |=> !refresh_req_o)
    else $error("refresh requested while host owns");
  chk_cpu_clk: assert property (
    $rose(cpu_clk_o) |=> !cpu_clk_o[*2] ##1 cpu_clk_o)
    else $error("processor clock shape wrong");
  cov_mem: cover property ($rose(lanes));
  cov_refr: cover property ($rose(refresh_req_o));
  cov_host: cover property (host_owns_i && host_upper_lane_sel_o);
endmodule : dlc_props

// File: dv/dlc_cpu_model.sv
// local processor bus model: address latch strobe and cycle strobes
module dlc_cpu_model
  import dlc_pkg::*;
(
  input wire logic mclk_i,
  output logic ale_o,
  output logic [19:0] addr_o,
  output dlc_pkg::dlc_cpu_ctl_s ctl_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ale_o = 1'b0;
    addr_o = 20'h00000;
    ctl_o = '0;
  end
  // kind 0 mem rd, 1 mem wr, 2 io rd, 3 io wr
  task automatic start(input logic [19:0] a, input logic bhe_b,
                       input logic [1:0] kind);
    @(negedge mclk_i);
    ale_o = 1'b1;
    addr_o = a;
    ctl_o.bhe_b = bhe_b;
    @(negedge mclk_i);
    ale_o = 1'b0;
    addr_o = ~a; // bus now carries data, address gone
    ctl_o = {kind == 2'h0, kind == 2'h1, kind == 2'h2, kind == 2'h3, bhe_b};
  endtask : start
  task automatic stop;
    @(negedge mclk_i);
    ctl_o[4:1] = 4'h0;
  endtask : stop
endmodule : dlc_cpu_model

// File: dv/dlc_lane_ctrl_tb_top.sv
// self-checking bench for the lane control block
module dlc_lane_ctrl_tb_top;
  import dlc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ale;
  logic [19:0] addr;
  dlc_cpu_ctl_s ctl;
  logic owns = 1'b0;
  logic hreq = 1'b0;
  logic hstb = 1'b0;
  logic [17:0] haddr = 18'h00000;
  logic hhi = 1'b0;
  logic hlo = 1'b0;
  logic [19:0] latched;
  dlc_xcvr_s xcvr;
  logic cup, clo, hup, hlo_sel, rreq;
  logic pclk, tclk, crst;
  dlc_dram_s dram;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  initial forever #50 mclk_i = ~mclk_i;

  dlc_cpu_model dlc_cpu_model_i (.mclk_i(mclk_i), .ale_o(ale),
    .addr_o(addr), .ctl_o(ctl));

  dlc_lane_ctrl dlc_lane_ctrl_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .ale_i(ale), .addr_i(addr), .cpu_ctl_i(ctl), .host_owns_i(owns),
    .host_req_i(hreq), .host_mem_strobe_i(hstb), .host_addr_i(haddr),
    .host_hi_byte_i(hhi), .host_lo_byte_i(hlo), .latched_addr_o(latched),
    .xcvr_o(xcvr), .cpu_upper_lane_en_o(cup), .cpu_lower_lane_en_o(clo),
    .host_upper_lane_sel_o(hup), .host_lower_lane_sel_o(hlo_sel),
    .dram_o(dram), .refresh_req_o(rreq), .cpu_clk_o(), .periph_clk_o(pclk),
    .timer_clk_o(tclk), .cpu_rst_b_o(crst));

  task automatic chk(input string what, input logic [19:0] exp,
                     input logic [19:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wait_ras;
    for (int n = 0; n < 8 && dram.ras !== 1'b1; n++) @(negedge mclk_i);
  endtask : wait_ras

  task automatic t_mem;
    logic [1:0] e;
    for (int i = 0; i < 3; i++) begin
      e = (i == 0) ? 2'h3 : 2'(i);
      dlc_cpu_model_i.start({19'h2A5C3, i == 2}, i == 1, 2'(i % 2));
      #1;
      chk("cpu lanes", 20'({cup, clo}), 20'(e));
      chk("mem xcvr", 20'(xcvr), 20'({e[0], e[1], 1'b0}));
      chk("latched", latched, {19'h2A5C3, i == 2});
      wait_ras();
      chk("ras", 20'(dram.ras), 20'h1);
      chk("row addr", 20'(dram.addr), 20'h001C3);
      @(negedge mclk_i);
      chk("cas lanes", 20'({dram.mux_col, dram.cas,
        dram.upper_lane_col_strobe, dram.lower_lane_col_strobe}),
        20'({2'h3, e}));
      chk("col addr", 20'(dram.addr), 20'h00152);
      dlc_cpu_model_i.stop();
      repeat (4) @(negedge mclk_i);
    end
    $display("t_mem done");
  endtask : t_mem

  task automatic t_io;
    logic seen;
    for (int i = 0; i < 4; i++) begin
      seen = 1'b0;
      dlc_cpu_model_i.start({19'h00021, i[1]}, 1'b1, 2'(2 + i % 2));
      #1;
      chk("io xcvr", 20'(xcvr), 20'({~i[1], 1'b0, i[1]}));
      repeat (5) begin
        @(negedge mclk_i);
        seen |= dram.upper_lane_col_strobe | dram.lower_lane_col_strobe;
      end
      chk("io lane strobes", 20'(seen), 20'h0);
      dlc_cpu_model_i.stop();
    end
    $display("t_io done");
  endtask : t_io

  task automatic t_host;
    @(negedge mclk_i);
    owns = 1'b1;
    for (int i = 1; i < 4; i++) begin
      {hhi, hlo} = 2'(i);
      haddr = 18'h155AA;
      hstb = 1'b1;
      #1;
      chk("host sels", 20'({hup, hlo_sel}), 20'(i));
      chk("cpu lanes host", 20'({cup, clo, xcvr}), 20'h0);
      wait_ras();
      @(negedge mclk_i);
      chk("host lanes", 20'({dram.upper_lane_col_strobe,
        dram.lower_lane_col_strobe}), 20'(i));
      hstb = 1'b0;
      repeat (4) @(negedge mclk_i);
    end
    owns = 1'b0;
    #1;
    chk("host sels off", 20'({hup, hlo_sel}), 20'h0);
    $display("t_host done");
  endtask : t_host

  task automatic t_refresh;
    logic seen = 1'b0;
    for (int n = 0; n < 130 && rreq !== 1'b1; n++) @(negedge mclk_i);
    chk("refresh req", 20'(rreq), 20'h1);
    wait_ras();
    chk("refresh ras only", 20'({dram.ras, dram.cas, rreq}),
      20'h4);
    chk("refresh row", 20'(dram.addr), 20'h00000);
    owns = 1'b1;
    hreq = 1'b1;
    repeat (260) begin
      @(negedge mclk_i);
      seen |= rreq;
    end
    chk("refresh held off", 20'(seen), 20'h0);
    owns = 1'b0;
    hreq = 1'b0;
    $display("t_refresh done");
  endtask : t_refresh

  task automatic t_clk;
    logic pc;
    logic tc;
    int np = 0;
    int nt = 0;
    pc = pclk;
    tc = tclk;
    repeat (48) begin
      @(negedge mclk_i);
      if (pclk !== pc) np++;
      if (tclk !== tc) nt++;
      pc = pclk;
      tc = tclk;
    end
    chk("periph toggles", 20'(np), 20'h00010);
    chk("timer toggles", 20'(nt), 20'h00004);
    chk("cpu reset out", 20'(crst), 20'h00001);
    $display("t_clk done");
  endtask : t_clk

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      give_verdict();
    end
  end

  initial begin
    repeat (3) @(negedge mclk_i);
    chk("cpu reset held", 20'(crst), 20'h00000);
    rst_b_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    t_mem();
    t_io();
    t_host();
    t_refresh();
    t_clk();
    give_verdict();
  end
endmodule : dlc_lane_ctrl_tb_top

bind dlc_lane_ctrl dlc_props dlc_props_i (.mclk_i, .rst_b_i, .cpu_ctl_i,
  .host_owns_i, .host_req_i, .xcvr_o, .cpu_upper_lane_en_o,
  .cpu_lower_lane_en_o, .host_upper_lane_sel_o, .host_lower_lane_sel_o,
  .dram_o, .refresh_req_o, .cpu_clk_o);
